//--- rtl/rtc_pin_pkg.sv
// constants, field layouts and state types of the rtc pin supervisor
// assumes a 20 MHz system clock and a 32768 Hz oscillator level on a plain input
`default_nettype none

package rtc_pin_pkg;

  // clock rates
  localparam int unsigned SYS_CLK_HZ   = 20_000_000;
  localparam int unsigned OSC_HZ       = 32_768;

  // interval lengths as printed, in milliseconds
  localparam int unsigned DEBOUNCE_MS  = 250;
  localparam int unsigned TRST_MS      = 250;
  localparam int unsigned TREC_MS      = 250;
  localparam int unsigned STOP_MS      = 100;
  localparam int unsigned OSC_START_MS = 1000;

  // least times round up to whole oscillator ticks or system cycles
  localparam longint unsigned DEBOUNCE_TICKS_DEF = (longint'(DEBOUNCE_MS) * OSC_HZ + 999) / 1000;
  localparam longint unsigned TRST_TICKS_DEF     = (longint'(TRST_MS) * OSC_HZ + 999) / 1000;
  localparam longint unsigned TREC_TICKS_DEF     = (longint'(TREC_MS) * OSC_HZ + 999) / 1000;
  localparam longint unsigned START_TICKS_DEF    = (longint'(OSC_START_MS) * OSC_HZ + 999) / 1000;
  localparam longint unsigned STOP_CYCLES_DEF    = (longint'(STOP_MS) * SYS_CLK_HZ + 999) / 1000;

  // counter widths
  localparam int unsigned TICK_W       = 16;
  localparam int unsigned STOP_W       = 22;
  localparam int unsigned PRESCALE_W   = 15;

  // prescaler taps for the square wave: 1 Hz, 1.024 kHz, 4.096 kHz, 8.192 kHz
  localparam int unsigned TAP_1HZ      = 14;
  localparam int unsigned TAP_1K       = 4;
  localparam int unsigned TAP_4K       = 2;
  localparam int unsigned TAP_8K       = 1;

  // register byte offsets on the avalon slave
  localparam logic [3:0] CTRL_OFS      = 4'h0;
  localparam logic [3:0] STATUS_OFS    = 4'h4;
  localparam logic [3:0] MASK_OFS      = 4'h8;
  localparam logic [3:0] STATE_OFS     = 4'hC;

  // control register, bit 5 downward
  typedef struct packed {
    logic alarm2_enable;
    logic alarm1_enable;
    logic oscillator_disable;
    logic rate_select_high;
    logic rate_select_low;
    logic interrupt_control_select;
  } ctrl_t;

  // event layout shared by status and mask
  typedef struct packed {
    logic osc_stop;
    logic power_fail;
    logic pushbutton;
    logic alarm2;
    logic alarm1;
  } event_t;

  localparam ctrl_t  CTRL_RESET   = 6'h01;
  localparam event_t STATUS_RESET = 5'h00;
  localparam event_t MASK_RESET   = 5'h00;

  typedef enum {
    RS_POWER,
    RS_RECOVER,
    RS_IDLE,
    RS_DEBOUNCE,
    RS_WAIT_RELEASE,
    RS_HOLD
  } reset_state_t;

endpackage : rtc_pin_pkg

`default_nettype wire

//--- rtl/rtc_pin_supervisor.sv
// pin-level output and supervisory logic of an i2c real-time clock:
// multifunction interrupt / square-wave pin, reset line with pushbutton,
// oscillator stop flag, 32 kHz output and the serial pin stage.
// assumes all inputs synchronous to sys_clk; osc_tick is the oscillator level.
`default_nettype none

// Behaviour
// - With interrupt_control_select at 0 the multifunction pin carries a square wave chosen by the rate bits.
// - With interrupt_control_select at 1 the pin pulls low while an enabled alarm has matched.
// - After power-up interrupt_control_select is 1 and both alarms are disabled.
// - The reset line is held low while the supply is low and, with the oscillator running, released only after the release delay.
// - The reset line is an open-drain output and a debounced pushbutton input.
// - A pushbutton request drives the reset line active just like a power failure.
// - With the oscillator disabled the release delay grows by the oscillator start-up time.
// - The recovery delay counts only with a running oscillator, plus start-up time when disabled.
// - The oscillator stop flag sets only after the oscillator has been stopped for the stop-detect interval.
// - The oscillator clock leaves on an open-drain pin that only pulls low.
// - A falling edge outside a reset cycle makes the device hold the line low for the debounce interval.
// - When the supply returns with the oscillator running the line stays low for the recovery time before release.
// - If the oscillator is not running when the supply returns the line is released at once.
module rtc_pin_supervisor
  import rtc_pin_pkg::*;
#(
  parameter logic [TICK_W-1:0] DEBOUNCE_TICKS = TICK_W'(DEBOUNCE_TICKS_DEF),
  parameter logic [TICK_W-1:0] TRST_TICKS     = TICK_W'(TRST_TICKS_DEF),
  parameter logic [TICK_W-1:0] TREC_TICKS     = TICK_W'(TREC_TICKS_DEF),
  parameter logic [TICK_W-1:0] START_TICKS    = TICK_W'(START_TICKS_DEF),
  parameter logic [STOP_W-1:0] STOP_CYCLES    = STOP_W'(STOP_CYCLES_DEF)
) (
  input  wire logic        sys_clk,          // system clock, 20 MHz
  input  wire logic        reset,            // synchronous, active high
  input  wire logic [3:0]  avs_address,      // byte address
  input  wire logic        avs_read,         // read request
  input  wire logic        avs_write,        // write request
  input  wire logic [31:0] avs_writedata,    // write data
  output logic      [31:0] avs_readdata,     // read data
  output logic             avs_waitrequest,  // stall
  output logic             irq,              // level interrupt
  input  wire logic        osc_tick,         // 32768 Hz oscillator level
  input  wire logic        osc_running,      // oscillator activity detector
  input  wire logic        supply_ok,        // supply above power_fail_threshold
  input  wire logic        alarm1_match,     // alarm 1 match pulse
  input  wire logic        alarm2_match,     // alarm 2 match pulse
  output logic             irq_sqw_out,      // pin level when driven, always 0
  output logic             irq_sqw_oe,       // pulls irq_or_square_wave_pin low
  input  wire logic        reset_line_in,    // reset_line pin level
  output logic             reset_line_out,   // pin level when driven, always 0
  output logic             reset_line_oe,    // pulls reset_line low
  output logic             osc_clock_out_o,  // pin level when driven, always 0
  output logic             osc_clock_out_oe, // pulls osc_clock_out low
  input  wire logic        scl_in,           // serial clock pin
  input  wire logic        sda_in,           // serial data pin level
  output logic             sda_out,          // pin level when driven, always 0
  output logic             sda_oe,           // pulls serial data low
  input  wire logic        sda_pull_low,     // protocol engine wants data low
  output logic             scl_rx,           // serial clock to protocol engine
  output logic             sda_rx            // serial data to protocol engine
);

  // bus slave state
  logic                ack_reg,    ack_next;
  logic [31:0]         rdata_reg,  rdata_next;
  ctrl_t               ctrl_reg,   ctrl_next;
  event_t              status_reg, status_next;
  event_t              mask_reg,   mask_next;
  // pin and timing state
  reset_state_t        rst_state_reg, rst_state_next;
  logic [TICK_W-1:0]   timer_reg,  timer_next;
  logic [STOP_W-1:0]   stop_cnt_reg, stop_cnt_next;
  logic [PRESCALE_W-1:0] pre_reg,  pre_next;
  logic                osc_prev_reg;
  logic                line_prev_reg;
  logic                irq_sqw_oe_reg, irq_sqw_oe_next;
  logic                osc_oe_reg;
  logic                scl_rx_reg, sda_rx_reg, sda_oe_reg;
  // combinational helpers
  logic                tick;
  logic                wr_now;
  event_t              evt;
  event_t              clr;
  logic                sqw_level;
  logic [TICK_W-1:0]   rec_len;
  logic [TICK_W-1:0]   hold_len;

  // address decode shared by read and write paths
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    return addr == ofs;
  endfunction : hit

  // one tick per rising edge of the oscillator level
  assign tick = osc_tick & ~osc_prev_reg;

  // start-up time added when the oscillator is disabled
  assign rec_len  = ctrl_reg.oscillator_disable ? TICK_W'(TREC_TICKS + START_TICKS) : TREC_TICKS;
  assign hold_len = ctrl_reg.oscillator_disable ? TICK_W'(TRST_TICKS + START_TICKS) : TRST_TICKS;

  // one wait state: the request is taken on the cycle after it appears
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_now          = avs_write & ack_reg;

  always_comb begin
    ack_next   = (avs_read | avs_write) & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read & ~ack_reg) begin
      rdata_next = 32'h0000_0000;
      if (hit(avs_address, CTRL_OFS)) begin
        rdata_next = {26'h0, ctrl_reg};
      end else if (hit(avs_address, STATUS_OFS)) begin
        rdata_next = {27'h0, status_reg};
      end else if (hit(avs_address, MASK_OFS)) begin
        rdata_next = {27'h0, mask_reg};
      end else if (hit(avs_address, STATE_OFS)) begin
        rdata_next = {28'h0, osc_running, reset_line_oe, reset_line_in, supply_ok};
      end
    end
  end

  // control and mask writes; unmapped writes are dropped
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    clr       = '0;
    if (wr_now && hit(avs_address, CTRL_OFS)) begin
      ctrl_next = ctrl_t'(avs_writedata[5:0]);
    end
    if (wr_now && hit(avs_address, MASK_OFS)) begin
      mask_next = event_t'(avs_writedata[4:0]);
    end
    if (wr_now && hit(avs_address, STATUS_OFS)) begin
      clr = event_t'(avs_writedata[4:0]);
    end
  end

  // sticky events; a set in the clearing cycle survives the clear
  always_comb begin
    status_next = event_t'((status_reg & ~clr) | evt);
  end

  assign irq = |(status_reg & mask_reg);

  always_comb begin
    evt.alarm1   = alarm1_match;
    evt.alarm2   = alarm2_match;
    evt.pushbutton = 1'b0;
    evt.power_fail = 1'b0;
    evt.osc_stop = 1'b0;
    rst_state_next = rst_state_reg;
    timer_next     = timer_reg;
    // a low supply forces the line low from any state
    if (!supply_ok) begin
      rst_state_next = RS_POWER;
      timer_next     = '0;
      evt.power_fail = (rst_state_reg != RS_POWER);
    end else begin
      unique case (rst_state_reg)
        RS_POWER: begin
          timer_next = '0;
          // no running oscillator, no recovery delay
          if (!osc_running) begin
            rst_state_next = RS_IDLE;
          end else begin
            rst_state_next = RS_RECOVER;
          end
        end
        RS_RECOVER: begin
          // only oscillator ticks advance the delay
          if (tick) begin
            if (timer_reg >= rec_len - TICK_W'(1)) begin
              rst_state_next = RS_IDLE;
            end else begin
              timer_next = timer_reg + TICK_W'(1);
            end
          end
        end
        RS_IDLE: begin
          // falling edge outside a reset cycle
          if (line_prev_reg && !reset_line_in) begin
            rst_state_next = RS_DEBOUNCE;
            timer_next     = '0;
            evt.pushbutton = 1'b1;
          end
        end
        RS_DEBOUNCE: begin
          if (tick) begin
            if (timer_reg >= DEBOUNCE_TICKS - TICK_W'(1)) begin
              rst_state_next = RS_WAIT_RELEASE;
            end else begin
              timer_next = timer_reg + TICK_W'(1);
            end
          end
        end
        RS_WAIT_RELEASE: begin
          // line released by us, wait for the button to let go
          if (reset_line_in) begin
            rst_state_next = RS_HOLD;
            timer_next     = '0;
          end
        end
        RS_HOLD: begin
          // pushbutton reset held for the reset active time
          if (tick) begin
            if (timer_reg >= hold_len - TICK_W'(1)) begin
              rst_state_next = RS_IDLE;
            end else begin
              timer_next = timer_reg + TICK_W'(1);
            end
          end
        end
      endcase
    end
    // flag only after a full stop-detect interval
    if (osc_running) begin
      stop_cnt_next = '0;
    end else if (stop_cnt_reg < STOP_CYCLES) begin
      stop_cnt_next = stop_cnt_reg + STOP_W'(1);
      evt.osc_stop  = (stop_cnt_reg == STOP_CYCLES - STOP_W'(1));
    end else begin
      stop_cnt_next = stop_cnt_reg;
    end
  end

  // square-wave prescaler runs off oscillator ticks
  always_comb begin
    pre_next = tick ? pre_reg + PRESCALE_W'(1) : pre_reg;
    unique case ({ctrl_reg.rate_select_high, ctrl_reg.rate_select_low})
      2'h0: sqw_level = pre_reg[TAP_1HZ];
      2'h1: sqw_level = pre_reg[TAP_1K];
      2'h2: sqw_level = pre_reg[TAP_4K];
      2'h3: sqw_level = pre_reg[TAP_8K];
    endcase
  end

  // multifunction pin: pull low for a pending enabled alarm or a low half-wave
  always_comb begin
    if (ctrl_reg.interrupt_control_select) begin
      // enabled alarm pulls the pin low
      irq_sqw_oe_next = (status_reg.alarm1 & ctrl_reg.alarm1_enable) |
                        (status_reg.alarm2 & ctrl_reg.alarm2_enable);
    end else begin
      // square wave from the selected tap
      irq_sqw_oe_next = ~sqw_level;
    end
  end

  // open-drain pins only ever pull low
  assign irq_sqw_out      = 1'b0;
  assign reset_line_out   = 1'b0;
  assign osc_clock_out_o  = 1'b0;
  assign sda_out          = 1'b0;
  assign irq_sqw_oe       = irq_sqw_oe_reg;
  assign osc_clock_out_oe = osc_oe_reg;
  assign sda_oe           = sda_oe_reg;
  assign scl_rx           = scl_rx_reg;
  assign sda_rx           = sda_rx_reg;
  assign avs_readdata     = rdata_reg;

  // line pulled low in every state of a reset cycle except RS_WAIT_RELEASE
  assign reset_line_oe = (rst_state_reg == RS_POWER) || (rst_state_reg == RS_RECOVER) ||
                         (rst_state_reg == RS_DEBOUNCE) || (rst_state_reg == RS_HOLD);

  // register stage for bus, control and events
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_reg    <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      ctrl_reg   <= CTRL_RESET;
      status_reg <= STATUS_RESET;
      mask_reg   <= MASK_RESET;
    end else begin
      ack_reg    <= ack_next;
      rdata_reg  <= rdata_next;
      ctrl_reg   <= ctrl_next;
      status_reg <= status_next;
      mask_reg   <= mask_next;
    end
  end

  // register stage for the supervisor and pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rst_state_reg  <= RS_POWER;
      timer_reg      <= '0;
      stop_cnt_reg   <= '0;
      pre_reg        <= '0;
      osc_prev_reg   <= 1'b0;
      line_prev_reg  <= 1'b1;
      irq_sqw_oe_reg <= 1'b0;
      osc_oe_reg     <= 1'b0;
      scl_rx_reg     <= 1'b1;
      sda_rx_reg     <= 1'b1;
      sda_oe_reg     <= 1'b0;
    end else begin
      rst_state_reg  <= rst_state_next;
      timer_reg      <= timer_next;
      stop_cnt_reg   <= stop_cnt_next;
      pre_reg        <= pre_next;
      osc_prev_reg   <= osc_tick;
      line_prev_reg  <= reset_line_in;
      irq_sqw_oe_reg <= irq_sqw_oe_next;
      // oscillator clock pulls low on its low phase
      osc_oe_reg     <= ~osc_tick;
      // serial clock is only sampled, never driven
      scl_rx_reg     <= scl_in;
      sda_rx_reg     <= sda_in;
      sda_oe_reg     <= sda_pull_low;
    end
  end

endmodule : rtc_pin_supervisor

`default_nettype wire

//--- testbench/rtc_pin_supervisor_checker.sv
// checker for the rtc pin supervisor, bound to its top-level ports
// assumes one sys_clk domain with synchronous active-high reset
`default_nettype none
module rtc_pin_supervisor_checker (
  input wire logic sys_clk,          // clock
  input wire logic reset,            // sync reset
  input wire logic osc_tick,         // oscillator level
  input wire logic osc_running,      // oscillator activity
  input wire logic supply_ok,        // supply good
  input wire logic irq_sqw_out,      // pin level
  input wire logic reset_line_in,    // reset line level
  input wire logic reset_line_out,   // pin level
  input wire logic reset_line_oe,    // reset pull-low
  input wire logic osc_clock_out_o,  // pin level
  input wire logic osc_clock_out_oe, // clock pull-low
  input wire logic scl_in,           // serial clock pin
  input wire logic scl_rx,           // serial clock copy
  input wire logic sda_in,           // serial data pin
  input wire logic sda_rx,           // serial data copy
  input wire logic sda_out,          // pin level
  input wire logic sda_oe,           // data pull-low
  input wire logic sda_pull_low      // engine request
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_no_high;
    irq_sqw_out == 1'b0 && reset_line_out == 1'b0 && osc_clock_out_o == 1'b0 && sda_out == 1'b0;
  endproperty
  a_no_high: assert property (p_no_high) else $error("open-drain pin driven high");
  // clock out is the inverted tick
  property p_osc_out;
    !$past(reset) |-> osc_clock_out_oe == !$past(osc_tick);
  endproperty
  a_osc_out: assert property (p_osc_out) else $error("clock output not following oscillator");
  property p_serial;
    !$past(reset) |-> scl_rx == $past(scl_in) && sda_rx == $past(sda_in) && sda_oe == $past(sda_pull_low);
  endproperty
  a_serial: assert property (p_serial) else $error("serial pin stage wrong");
  property p_power;
    !supply_ok |=> reset_line_oe;
  endproperty
  a_power: assert property (p_power) else $error("reset line not pulled on low supply");
  property p_bypass;
    $rose(supply_ok) && !osc_running |=> !reset_line_oe;
  endproperty
  a_bypass: assert property (p_bypass) else $error("recovery not bypassed");
  property p_recover;
    $rose(supply_ok) && osc_running |=> reset_line_oe [*8];
  endproperty
  a_recover: assert property (p_recover) else $error("recovery too short");
  property p_button;
    $fell(reset_line_in) && !reset_line_oe && !$past(reset_line_oe) && supply_ok |=> reset_line_oe;
  endproperty
  a_button: assert property (p_button) else $error("button press not answered");
  property p_hold;
    $rose(reset_line_oe) && osc_running |-> reset_line_oe [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("reset pulse too short");
endmodule : rtc_pin_supervisor_checker
`default_nettype wire

//--- testbench/rtc_far_side.sv
// far side of the supervisor: host serial controller, pushbutton, pull-ups
// assumes bench drives press and host_run just after sys_clk edges
`default_nettype none
module rtc_far_side (
  input  wire logic sys_clk,       // clock
  input  wire logic host_run,      // host frame active
  input  wire logic press,         // button closed
  input  wire logic reset_line_oe, // device pulls reset
  input  wire logic sda_oe,        // device pulls data
  output logic      reset_line_in, // resolved reset line
  output logic      scl_in,        // host serial clock
  output logic      sda_in         // resolved data line
);
  logic [2:0] scl_cnt_reg = 3'h0;
  logic       host_low_reg = 1'b0;
  assign reset_line_in = ~(reset_line_oe | press);
  // host clocks only within a frame, idle high
  always_ff @(posedge sys_clk) begin
    scl_cnt_reg <= host_run ? scl_cnt_reg + 3'h1 : 3'h0;
    if (host_run && scl_cnt_reg == 3'h7) host_low_reg <= ~host_low_reg;
  end
  assign scl_in = host_run ? scl_cnt_reg[2] : 1'b1;
  // released data line floats to the pull-up
  assign sda_in = ~(sda_oe | (host_run & host_low_reg));
endmodule : rtc_far_side
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the rtc pin supervisor
// assumes rtc_far_side and the checker compiled before it
`default_nettype none
module testbench
  import rtc_pin_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        osc_tick = 1'b0, osc_running = 1'b1, supply_ok = 1'b1, irq_sqw_out, irq_sqw_oe;
  logic        alarm1_match = 1'b0, alarm2_match = 1'b0, reset_line_in, reset_line_out, reset_line_oe;
  logic        osc_clock_out_o, osc_clock_out_oe, scl_in, sda_in, sda_out, sda_oe, scl_rx, sda_rx;
  logic        sda_pull_low = 1'b0, press = 1'b0, host_run = 1'b0;
  logic [2:0]  div = 3'h0;
  int          mismatches = 0, tests_run = 0, cycles = 0;
  rtc_pin_supervisor #(.DEBOUNCE_TICKS(16'h4), .TRST_TICKS(16'h4), .TREC_TICKS(16'h4), .START_TICKS(16'h8),
    .STOP_CYCLES(22'h14)) dut_u (.sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .irq, .osc_tick, .osc_running, .supply_ok, .alarm1_match, .alarm2_match,
    .irq_sqw_out, .irq_sqw_oe, .reset_line_in, .reset_line_out, .reset_line_oe, .osc_clock_out_o,
    .osc_clock_out_oe, .scl_in, .sda_in, .sda_out, .sda_oe, .sda_pull_low, .scl_rx, .sda_rx);
  rtc_far_side far_u (.sys_clk, .host_run, .press, .reset_line_oe, .sda_oe, .reset_line_in, .scl_in, .sda_in);
  always #25 sys_clk = ~sys_clk;
  // oscillator stand-in: a tick every 16 cycles keeps counts short
  always @(posedge sys_clk) begin
    div <= div + 3'h1;
    if (div == 3'h7) osc_tick <= ~osc_tick;
    sda_pull_low <= div[2];
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      final_report;
    end
  end
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // avalon master: hold until waitrequest seen low, act at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  // cycles the reset line stays pulled, sampled mid-cycle
  task automatic count_oe(output int n);
    n = 0;
    while (reset_line_oe === 1'b1 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : count_oe
  task automatic t_regs;
    logic [31:0] d;
    wr(4'h2, 32'hFFFFFFFF);
    bus(1'b0, CTRL_OFS, 32'h0, d);
    check(d, 32'h00000001);
    bus(1'b0, STATUS_OFS, 32'h0, d);
    check(d, 32'h00000000);
    bus(1'b0, MASK_OFS, 32'h0, d);
    check(d, 32'h00000000);
    bus(1'b0, 4'h2, 32'h0, d);
    check(d, 32'h00000000);
    bus(1'b0, STATE_OFS, 32'h0, d);
    check(d, 32'h0000000B);
    check(32'(irq_sqw_oe), 32'h0);
  endtask : t_regs
  task automatic t_power(input logic [31:0] ctrl, input int lo, input int hi);
    logic [31:0] d;
    int n;
    wr(CTRL_OFS, ctrl);
    @(posedge sys_clk) supply_ok <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(32'(reset_line_oe), 32'h1);
    supply_ok <= 1'b1;
    count_oe(n);
    check(32'(n >= lo && n <= hi), 32'h1);
    bus(1'b0, STATUS_OFS, 32'h0, d);
    check(d & 32'h8, 32'h8);
    wr(STATUS_OFS, 32'h8);
  endtask : t_power
  task automatic t_bypass;
    int n;
    wr(CTRL_OFS, 32'h01);
    @(posedge sys_clk) osc_running <= 1'b0;
    @(posedge sys_clk) supply_ok <= 1'b0;
    repeat (3) @(posedge sys_clk);
    supply_ok <= 1'b1;
    count_oe(n);
    check(32'(n <= 2), 32'h1);
    @(posedge sys_clk) osc_running <= 1'b1;
  endtask : t_bypass
  task automatic t_button;
    logic [31:0] d;
    int n;
    @(posedge sys_clk) press <= 1'b1;
    repeat (2) @(negedge sys_clk);
    check(32'(reset_line_oe), 32'h1);
    count_oe(n);
    check(32'(n >= 44 && n <= 70), 32'h1);
    bus(1'b0, STATUS_OFS, 32'h0, d);
    check(d & 32'h4, 32'h4);
    @(posedge sys_clk) press <= 1'b0;
    repeat (2) @(negedge sys_clk);
    check(32'(reset_line_oe), 32'h1);
    count_oe(n);
    check(32'(n >= 44 && n <= 70), 32'h1);
    wr(STATUS_OFS, 32'h4);
  endtask : t_button
  task automatic alarm(input logic two, input logic [31:0] clr, input logic pin, input logic req);
    @(posedge sys_clk) {alarm2_match, alarm1_match} <= two ? 2'h2 : 2'h1;
    @(posedge sys_clk) {alarm2_match, alarm1_match} <= 2'h0;
    repeat (2) @(negedge sys_clk);
    check(32'(irq_sqw_oe), 32'(pin));
    check(32'(irq), 32'(req));
    wr(STATUS_OFS, clr);
    repeat (2) @(negedge sys_clk);
    check(32'({irq_sqw_oe, irq}), 32'h0);
  endtask : alarm
  task automatic t_irq;
    wr(MASK_OFS, 32'h3);
    wr(CTRL_OFS, 32'h11);
    alarm(1'b0, 32'h1, 1'b1, 1'b1);
    alarm(1'b1, 32'h2, 1'b0, 1'b1);
    wr(MASK_OFS, 32'h0);
    alarm(1'b0, 32'h1, 1'b1, 1'b0);
  endtask : t_irq
  task automatic t_osf;
    logic [31:0] d;
    @(posedge sys_clk) osc_running <= 1'b0;
    repeat (18) @(posedge sys_clk);
    osc_running <= 1'b1;
    bus(1'b0, STATUS_OFS, 32'h0, d);
    check(d & 32'h10, 32'h0);
    @(posedge sys_clk) osc_running <= 1'b0;
    repeat (22) @(posedge sys_clk);
    osc_running <= 1'b1;
    bus(1'b0, STATUS_OFS, 32'h0, d);
    check(d & 32'h10, 32'h10);
  endtask : t_osf
  // toggles counted over 1024 cycles for every rate code
  task automatic t_sqw;
    int n, e;
    logic p;
    host_run <= 1'b1;
    for (int rs = 0; rs < 4; rs++) begin
      wr(CTRL_OFS, 32'(rs << 1));
      repeat (40) @(negedge sys_clk);
      n = 0;
      p = irq_sqw_oe;
      repeat (1024) begin
        @(negedge sys_clk);
        n += int'(irq_sqw_oe !== p);
        p = irq_sqw_oe;
      end
      e = 64 >> (rs == 0 ? TAP_1HZ : rs == 1 ? TAP_1K : rs == 2 ? TAP_4K : TAP_8K);
      check(32'(n >= e - 1 && n <= e + 1), 32'h1);
    end
    @(posedge sys_clk) host_run <= 1'b0;
  endtask : t_sqw
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (100) @(posedge sys_clk);
    t_regs;
    t_power(32'h01, 46, 70);
    t_power(32'h09, 174, 200);
    t_bypass;
    t_button;
    t_irq;
    t_osf;
    t_sqw;
    final_report;
  end
endmodule : testbench
bind rtc_pin_supervisor rtc_pin_supervisor_checker chk_u (.sys_clk, .reset, .osc_tick, .osc_running, .supply_ok,
  .irq_sqw_out, .reset_line_in, .reset_line_out, .reset_line_oe, .osc_clock_out_o, .osc_clock_out_oe, .scl_in,
  .scl_rx, .sda_in, .sda_rx, .sda_out, .sda_oe, .sda_pull_low);
`default_nettype wire
